/* core/cfb_exec_unit.sv */
// Flags, logic operation and control transfer execution unit
`timescale 1ns/100ps
`default_nettype none
module cfb_exec_unit
    import cfb_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        op_valid_i,
    input  wire cfb_op_e     op_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [7:0]  imm1_i,
    input  wire logic [7:0]  imm2_i,
    input  wire logic [7:0]  rel_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        bit_i,
    input  wire logic        dst_acc_i,
    input  wire logic [1:0]  ilen_i,
    input  wire logic [15:0] data_pointer_i,
    output logic [7:0]       acc_o,
    output logic [7:0]       status_word_o,
    output logic [15:0]      instruction_counter_o,
    output logic [7:0]       stack_top_index_o,
    output logic [7:0]       byte_o,
    output logic             byte_we_o,
    output logic             bit_o,
    output logic             bit_we_o,
    output logic             branch_taken_o,
    output logic             prio_release_o
);
    logic [7:0]  acc, next_acc;
    logic        carry_flag, next_carry_flag;
    logic        half_carry_flag, next_half_carry_flag;
    logic        signed_range_flag, next_signed_range_flag;
    logic        parity_flag;
    logic [15:0] instruction_counter, next_instruction_counter;
    logic [7:0]  stack_top_index, next_stack_top_index;
    logic [7:0]  byte_q, next_byte_q;
    logic        byte_we, next_byte_we;
    logic        bit_q, next_bit_q;
    logic        bit_we, next_bit_we;
    logic        taken, next_taken;
    logic        release_q, next_release_q;
    logic        push_en;
    logic [15:0] push_val;
    logic [7:0]  stack_mem [STK_DEPTH];
    logic [15:0] seq_pc;
    logic [15:0] rel_target;
    logic [15:0] ret_addr;
    logic [7:0]  src1, src2;
    logic        br;

    cfb_alu_if alu ();
    cfb_addsub i_cfb_addsub (.bus(alu.alu));

    // Length of the current instruction, fixed for calls, direct jumps and all branches except the decrement branch
    function automatic logic [15:0] op_len(input cfb_op_e op,
                                           input logic [1:0] ilen);
        case (op)
            CFB_SHORT_PAGE_CALL, CFB_PAGE_JUMP: op_len = LEN_PAGE;
            CFB_LONG_CALL, CFB_LONG_JUMP:       op_len = LEN_LONG;
            CFB_RELATIVE_JUMP, CFB_BR_ACC_ZERO, CFB_BR_ACC_NONZERO,
            CFB_BR_CARRY, CFB_BR_NO_CARRY:      op_len = LEN_REL;
            CFB_BR_BIT_ONE, CFB_BR_BIT_ZERO,
            CFB_BR_TEST_CLEAR:                  op_len = LEN_BITBR;
            CFB_CMP_BRANCH:                     op_len = LEN_CMPBR;
            default:                            op_len = {14'h0000, ilen};
        endcase
    endfunction

    assign seq_pc = instruction_counter + op_len(op_i, ilen_i);
    assign rel_target = seq_pc + {{8{rel_i[7]}}, rel_i};
    assign ret_addr = {stack_mem[stack_top_index],
                       stack_mem[stack_top_index - 8'h01]};
    assign src1 = dst_acc_i ? acc : byte_i;
    assign src2 = dst_acc_i ? byte_i : imm1_i;

    always_comb begin
        alu.a   = acc;
        alu.b   = byte_i;
        alu.cin = 1'b0;
        alu.sub = 1'b0;
        case (op_i)
            CFB_ADDC: alu.cin = carry_flag;
            CFB_SUBB: begin
                alu.cin = carry_flag;
                alu.sub = 1'b1;
            end
            CFB_CMP_BRANCH: begin
                alu.a   = src1;
                alu.b   = src2;
                alu.sub = 1'b1;
            end
            CFB_DEC_BRANCH: begin
                alu.a   = byte_i;
                alu.b   = 8'h01;
                alu.sub = 1'b1;
            end
            default: ;
        endcase
    end

    always_comb begin
        next_acc = acc;
        next_carry_flag = carry_flag;
        next_half_carry_flag = half_carry_flag;
        next_signed_range_flag = signed_range_flag;
        next_instruction_counter = instruction_counter;
        next_stack_top_index = stack_top_index;
        next_byte_q = byte_q;
        next_byte_we = 1'b0;
        next_bit_q = bit_q;
        next_bit_we = 1'b0;
        next_taken = 1'b0;
        next_release_q = 1'b0;
        push_en = 1'b0;
        push_val = seq_pc;
        br = 1'b0;
        if (op_valid_i) begin
            next_instruction_counter = seq_pc;
            case (op_i)
                CFB_ADD, CFB_ADDC, CFB_SUBB: begin
                    next_acc = alu.res;
                    next_carry_flag = alu.cy;
                    next_half_carry_flag = alu.ac;
                    next_signed_range_flag = alu.ov;
                end
                CFB_ACC_LOAD: next_acc = byte_i;
                CFB_STATUS_WR: begin
                    // Odd bit count position of the written value is dropped
                    next_carry_flag = byte_i[SW_CY];
                    next_half_carry_flag = byte_i[SW_AC];
                    next_signed_range_flag = byte_i[SW_OV];
                end
                CFB_ZERO_ACC: next_acc = ACC_RST;
                CFB_ZERO_BIT, CFB_FORCE_ONE_BIT: begin
                    next_bit_q = (op_i == CFB_FORCE_ONE_BIT);
                    next_bit_we = 1'b1;
                end
                CFB_INVERT_ACC: next_acc = ~acc;
                CFB_INVERT_BIT: begin
                    next_bit_q = ~bit_i;
                    next_bit_we = 1'b1;
                end
                CFB_ROTATE_LEFT: next_acc = {acc[6:0], acc[7]};
                CFB_ROTATE_RIGHT: next_acc = {acc[0], acc[7:1]};
                CFB_ROTATE_LEFT_C: begin
                    next_acc = {acc[6:0], carry_flag};
                    next_carry_flag = acc[7];
                end
                CFB_ROTATE_RIGHT_C: begin
                    next_acc = {carry_flag, acc[7:1]};
                    next_carry_flag = acc[0];
                end
                CFB_NIBBLE_SWAP: next_acc = {acc[3:0], acc[7:4]};
                CFB_AND_BYTE, CFB_OR_BYTE, CFB_XOR_BYTE: begin
                    if (op_i == CFB_AND_BYTE) begin
                        next_byte_q = src1 & src2;
                    end else if (op_i == CFB_OR_BYTE) begin
                        next_byte_q = src1 | src2;
                    end else begin
                        next_byte_q = src1 ^ src2;
                    end
                    if (dst_acc_i) begin
                        next_acc = next_byte_q;
                    end else begin
                        next_byte_we = 1'b1;
                    end
                end
                CFB_AND_BIT: next_carry_flag = carry_flag & bit_i;
                CFB_OR_BIT: next_carry_flag = carry_flag | bit_i;
                CFB_SHORT_PAGE_CALL, CFB_PAGE_JUMP: begin
                    next_instruction_counter = {seq_pc[PC_W-1:PAGE_HI],
                        opcode_i[7:OPC_PAGE_LO], imm1_i};
                    push_en = (op_i == CFB_SHORT_PAGE_CALL);
                end
                CFB_LONG_CALL, CFB_LONG_JUMP: begin
                    next_instruction_counter = {imm1_i, imm2_i};
                    push_en = (op_i == CFB_LONG_CALL);
                end
                CFB_CALL_EXIT, CFB_INTERRUPT_EXIT: begin
                    next_instruction_counter = ret_addr;
                    next_stack_top_index = stack_top_index - STK_STEP;
                    next_release_q = (op_i == CFB_INTERRUPT_EXIT);
                end
                CFB_RELATIVE_JUMP: br = 1'b1;
                CFB_INDEXED_JUMP:
                    next_instruction_counter =
                        data_pointer_i + {8'h00, acc};
                CFB_BR_ACC_ZERO: br = (acc == 8'h00);
                CFB_BR_ACC_NONZERO: br = (acc != 8'h00);
                CFB_BR_CARRY: br = carry_flag;
                CFB_BR_NO_CARRY: br = ~carry_flag;
                CFB_BR_BIT_ONE: br = bit_i;
                CFB_BR_BIT_ZERO: br = ~bit_i;
                CFB_BR_TEST_CLEAR: begin
                    br = bit_i;
                    next_bit_q = 1'b0;
                    next_bit_we = bit_i;
                end
                CFB_CMP_BRANCH: begin
                    br = (src1 != src2);
                    next_carry_flag = alu.cy;
                end
                CFB_DEC_BRANCH: begin
                    next_byte_q = alu.res;
                    next_byte_we = 1'b1;
                    br = (alu.res != 8'h00);
                end
                default: ;
            endcase
            if (push_en) begin
                next_stack_top_index = stack_top_index + STK_STEP;
            end
            if (br) begin
                next_instruction_counter = rel_target;
            end
            next_taken = br;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc <= ACC_RST;
            carry_flag <= 1'b0;
            half_carry_flag <= 1'b0;
            signed_range_flag <= 1'b0;
            parity_flag <= 1'b0;
            instruction_counter <= PC_RST;
            stack_top_index <= STK_RST;
            byte_q <= ACC_RST;
            byte_we <= 1'b0;
            bit_q <= 1'b0;
            bit_we <= 1'b0;
            taken <= 1'b0;
            release_q <= 1'b0;
        end else begin
            acc <= next_acc;
            carry_flag <= next_carry_flag;
            half_carry_flag <= next_half_carry_flag;
            signed_range_flag <= next_signed_range_flag;
            parity_flag <= ^next_acc;
            instruction_counter <= next_instruction_counter;
            stack_top_index <= next_stack_top_index;
            byte_q <= next_byte_q;
            byte_we <= next_byte_we;
            bit_q <= next_bit_q;
            bit_we <= next_bit_we;
            taken <= next_taken;
            release_q <= next_release_q;
        end
    end

    // Stack contents need no reset; low byte lands one above the old index
    always_ff @(posedge clk_sys_i) begin
        if (!rst_i && push_en) begin
            stack_mem[stack_top_index + 8'h01] <= push_val[7:0];
            stack_mem[stack_top_index + 8'h02] <= push_val[15:8];
        end
    end

    assign acc_o = acc;
    assign status_word_o = {carry_flag, half_carry_flag, 3'b000,
                            signed_range_flag, 1'b0, parity_flag};
    assign instruction_counter_o = instruction_counter;
    assign stack_top_index_o = stack_top_index;
    assign byte_o = byte_q;
    assign byte_we_o = byte_we;
    assign bit_o = bit_q;
    assign bit_we_o = bit_we;
    assign branch_taken_o = taken;
    assign prio_release_o = release_q;

    // Checking helpers
    logic [8:0] add_chk;
    logic [4:0] nib_chk;
    assign add_chk = {1'b0, acc} + {1'b0, byte_i};
    assign nib_chk = {1'b0, acc[3:0]} + {1'b0, byte_i[3:0]};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_add_carry: assert property (
        op_valid_i && op_i == CFB_ADD |=> carry_flag == $past(add_chk[8]) &&
        half_carry_flag == $past(nib_chk[4]))
        else $error("add carry flags wrong");
    a_add_range: assert property (
        op_valid_i && op_i == CFB_ADD && acc[7] == byte_i[7] |=>
        signed_range_flag == (acc[7] != $past(acc[7])))
        else $error("add signed range wrong");
    a_parity_track: assert property (
        parity_flag == ^acc)
        else $error("odd bit count flag stale");
    a_status_keep: assert property (
        op_valid_i && op_i == CFB_STATUS_WR |=> parity_flag == $past(^acc))
        else $error("status write changed odd bit count");
    a_invert_flags: assert property (
        op_valid_i && op_i == CFB_INVERT_ACC |=> acc == ~$past(acc) &&
        $stable(status_word_o))
        else $error("invert touched flags");
    a_swap_nibble: assert property (
        op_valid_i && op_i == CFB_NIBBLE_SWAP |=>
        acc == {$past(acc[3:0]), $past(acc[7:4])})
        else $error("nibble exchange wrong");
    a_call_stack: assert property (
        op_valid_i && op_i == CFB_SHORT_PAGE_CALL |=>
        stack_top_index == $past(stack_top_index) + STK_STEP)
        else $error("call stack index not raised by two");
    a_call_exit_pair: assert property (
        (op_valid_i && op_i == CFB_SHORT_PAGE_CALL) ##1
        (op_valid_i && op_i == CFB_CALL_EXIT) |=>
        instruction_counter == $past(seq_pc, 2))
        else $error("call exit did not return to next address");
    // A second exit right behind the first may hold the pulse legally
    a_exit_release: assert property (
        op_valid_i && op_i == CFB_INTERRUPT_EXIT |=> prio_release_o ##1
        (!prio_release_o || $past(op_valid_i && op_i == CFB_INTERRUPT_EXIT)))
        else $error("priority release not one pulse");
    a_rel_target: assert property (
        op_valid_i && op_i == CFB_RELATIVE_JUMP |=>
        instruction_counter == $past(rel_target) && branch_taken_o)
        else $error("relative target wrong");
    a_cmp_carry: assert property (
        op_valid_i && op_i == CFB_CMP_BRANCH |=>
        carry_flag == ($past(src1) < $past(src2)) &&
        branch_taken_o == ($past(src1) != $past(src2)))
        else $error("compare branch wrong");
    a_dec_write: assert property (
        op_valid_i && op_i == CFB_DEC_BRANCH |=> byte_we_o &&
        byte_o == $past(byte_i) - 8'h01 && branch_taken_o == (byte_o != 8'h00))
        else $error("decrement branch wrong");

    c_long_call: cover property (op_valid_i && op_i == CFB_LONG_CALL);
    c_test_clear: cover property (op_valid_i && op_i == CFB_BR_TEST_CLEAR &&
                                  bit_i);
    c_add_overflow: cover property (op_valid_i && op_i == CFB_ADD ##1
                                    signed_range_flag);
endmodule
`default_nettype wire

/* shared/cfb_pkg.sv */
// Package of constants and operation codes for the flags, logic and branch unit
package cfb_pkg;
    localparam int PC_W = 16;
    localparam int STK_DEPTH = 256;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] STK_RST = 8'h07;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] STK_STEP = 8'h02;
    localparam logic [15:0] LEN_PAGE = 16'h0002;
    localparam logic [15:0] LEN_LONG = 16'h0003;
    localparam logic [15:0] LEN_REL = 16'h0002;
    localparam logic [15:0] LEN_BITBR = 16'h0003;
    localparam logic [15:0] LEN_CMPBR = 16'h0003;
    localparam int PAGE_HI = 11;
    localparam int OPC_PAGE_LO = 5;
    // Status word field positions
    localparam int SW_CY = 7;
    localparam int SW_AC = 6;
    localparam int SW_OV = 2;
    localparam int SW_P = 0;
    typedef enum logic [5:0] {
        CFB_NOP, CFB_ADD, CFB_ADDC, CFB_SUBB, CFB_ACC_LOAD, CFB_STATUS_WR,
        CFB_ZERO_ACC, CFB_ZERO_BIT, CFB_FORCE_ONE_BIT, CFB_INVERT_ACC,
        CFB_INVERT_BIT, CFB_ROTATE_LEFT, CFB_ROTATE_LEFT_C, CFB_ROTATE_RIGHT,
        CFB_ROTATE_RIGHT_C, CFB_NIBBLE_SWAP, CFB_AND_BYTE, CFB_OR_BYTE,
        CFB_XOR_BYTE, CFB_AND_BIT, CFB_OR_BIT, CFB_SHORT_PAGE_CALL,
        CFB_LONG_CALL, CFB_CALL_EXIT, CFB_INTERRUPT_EXIT, CFB_PAGE_JUMP,
        CFB_LONG_JUMP, CFB_RELATIVE_JUMP, CFB_INDEXED_JUMP, CFB_BR_ACC_ZERO,
        CFB_BR_ACC_NONZERO, CFB_BR_CARRY, CFB_BR_NO_CARRY, CFB_BR_BIT_ONE,
        CFB_BR_BIT_ZERO, CFB_BR_TEST_CLEAR, CFB_CMP_BRANCH, CFB_DEC_BRANCH
    } cfb_op_e;
endpackage

/* shared/cfb_alu_if.sv */
// Interface between the core and its add and subtract slice
`timescale 1ns/100ps
`default_nettype none
interface cfb_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic       sub;
    logic [7:0] res;
    logic       cy;
    logic       ac;
    logic       ov;
    modport user (output a, b, cin, sub, input res, cy, ac, ov);
    modport alu  (input a, b, cin, sub, output res, cy, ac, ov);
endinterface
`default_nettype wire

/* core/cfb_addsub.sv */
// Add and subtract slice producing carry, half carry and signed range flags
`timescale 1ns/100ps
`default_nettype none
module cfb_addsub (
    cfb_alu_if.alu bus
);
    logic [4:0] low;
    logic [3:0] mid;
    logic [1:0] top;

    always_comb begin
        if (bus.sub) begin
            // The top bit of each slice (low[4], mid[3], top[1]) is the borrow out of that slice
            low = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cin};
            mid = {1'b0, bus.a[6:4]} - {1'b0, bus.b[6:4]} - {3'h0, low[4]};
            top = {1'b0, bus.a[7]} - {1'b0, bus.b[7]} - {1'b0, mid[3]};
        end else begin
            low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
            mid = {1'b0, bus.a[6:4]} + {1'b0, bus.b[6:4]} + {3'h0, low[4]};
            top = {1'b0, bus.a[7]} + {1'b0, bus.b[7]} + {1'b0, mid[3]};
        end
    end

    assign bus.res = {top[0], mid[2:0], low[3:0]};
    assign bus.cy  = top[1];
    assign bus.ac  = low[4];
    assign bus.ov  = top[1] ^ mid[3];
endmodule
`default_nettype wire

/* verification/cpu_flags_logic_branch_unit_test.sv */
// Self-checking bench for the flags, logic and branch execution unit
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_logic_branch_unit_test;
    import cfb_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        op_valid_i = 1'b0;
    cfb_op_e     op_i = CFB_NOP;
    logic [7:0]  opcode_i = 8'h00;
    logic [7:0]  imm1_i = 8'h00;
    logic [7:0]  imm2_i = 8'h00;
    logic [7:0]  rel_i = 8'h00;
    logic [7:0]  byte_i = 8'h00;
    logic        bit_i = 1'b0;
    logic [1:0]  ilen_i = 2'h1;
    logic        dst_acc_i = 1'b0;
    logic        dst_sel = 1'b0;
    wire  [7:0]  acc_o, status_word_o, stack_top_index_o, byte_o;
    wire  [15:0] instruction_counter_o;
    wire         byte_we_o, bit_o, bit_we_o, branch_taken_o, prio_release_o;
    wire  [52:0] obs;
    logic [7:0]  m_acc, m_sp;
    logic [15:0] m_pc;
    logic        m_cy, m_ac, m_ov, v_d;
    logic [7:0]  stk [256];
    logic [105:0] q_exp [$];
    logic [105:0] ex;
    logic [31:0] lfsr = 32'h87d567f4;
    int          err_total = 0;
    int          check_count = 0;
    cfb_op_e     tbl [34] = '{CFB_ADD, CFB_ADDC, CFB_SUBB, CFB_STATUS_WR,
        CFB_ZERO_ACC, CFB_ZERO_BIT, CFB_FORCE_ONE_BIT, CFB_INVERT_ACC,
        CFB_INVERT_BIT, CFB_ROTATE_LEFT, CFB_ROTATE_LEFT_C, CFB_ROTATE_RIGHT,
        CFB_ROTATE_RIGHT_C, CFB_NIBBLE_SWAP, CFB_AND_BYTE, CFB_OR_BYTE,
        CFB_XOR_BYTE, CFB_AND_BIT, CFB_OR_BIT, CFB_SHORT_PAGE_CALL,
        CFB_LONG_CALL, CFB_PAGE_JUMP, CFB_LONG_JUMP, CFB_RELATIVE_JUMP,
        CFB_INDEXED_JUMP, CFB_BR_ACC_ZERO, CFB_BR_ACC_NONZERO, CFB_BR_CARRY,
        CFB_BR_NO_CARRY, CFB_BR_BIT_ONE, CFB_BR_BIT_ZERO, CFB_BR_TEST_CLEAR,
        CFB_CMP_BRANCH, CFB_DEC_BRANCH};
    // The random mix also picks whether the accumulator is the first operand
    cfb_exec_unit i_cfb_exec_unit (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .opcode_i(opcode_i),
        .imm1_i(imm1_i), .imm2_i(imm2_i), .rel_i(rel_i), .byte_i(byte_i),
        .bit_i(bit_i), .dst_acc_i(dst_acc_i), .ilen_i(ilen_i),
        .data_pointer_i({imm2_i, imm1_i}), .acc_o(acc_o),
        .status_word_o(status_word_o),
        .instruction_counter_o(instruction_counter_o),
        .stack_top_index_o(stack_top_index_o), .byte_o(byte_o),
        .byte_we_o(byte_we_o), .bit_o(bit_o), .bit_we_o(bit_we_o),
        .branch_taken_o(branch_taken_o), .prio_release_o(prio_release_o));
    assign obs = {acc_o, status_word_o, instruction_counter_o,
        stack_top_index_o, byte_we_o, byte_o, bit_we_o, bit_o,
        branch_taken_o, prio_release_o};
    always #5 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [52:0] got, input logic [52:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_op(input cfb_op_e op, input logic [7:0] opc, i1, i2,
                         rl, by, input logic bt, input logic [1:0] il);
        logic [8:0]  s;
        logic [4:0]  h;
        logic [7:0]  l7, bv, f1, f2;
        logic [15:0] nx, tgt;
        logic        c, bwe, bitwe, bitv, tk, pr, jmp, tcare;
        @(negedge clk_sys_i);
        op_i = op;
        {opcode_i, imm1_i, imm2_i, rel_i, byte_i} = {opc, i1, i2, rl, by};
        {dst_acc_i, bit_i, ilen_i, op_valid_i} = {dst_sel, bt, il, 1'b1};
        nx = m_pc + {14'h0, il};
        f1 = dst_sel ? m_acc : by;
        f2 = dst_sel ? by : i1;
        {bwe, bv, bitwe, bitv, tk, pr, jmp, tcare} = {1'b0, 8'h00, 6'h01};
        tgt = nx;
        case (op)
            CFB_ADD, CFB_ADDC, CFB_SUBB: begin
                c = (op == CFB_ADD) ? 1'b0 : m_cy;
                if (op == CFB_SUBB) begin
                    s = {1'b0, m_acc} - {1'b0, by} - {8'h00, c};
                    h = {1'b0, m_acc[3:0]} - {1'b0, by[3:0]} - {4'h0, c};
                    l7 = {1'b0, m_acc[6:0]} - {1'b0, by[6:0]} - {7'h00, c};
                end else begin
                    s = {1'b0, m_acc} + {1'b0, by} + {8'h00, c};
                    h = {1'b0, m_acc[3:0]} + {1'b0, by[3:0]} + {4'h0, c};
                    l7 = {1'b0, m_acc[6:0]} + {1'b0, by[6:0]} + {7'h00, c};
                end
                {m_cy, m_ac, m_ov, m_acc} = {s[8], h[4], s[8] ^ l7[7], s[7:0]};
            end
            CFB_STATUS_WR: {m_cy, m_ac, m_ov} = {by[7], by[6], by[2]};
            CFB_ZERO_ACC: m_acc = 8'h00;
            CFB_ZERO_BIT: {bitwe, bitv} = 2'b10;
            CFB_FORCE_ONE_BIT: {bitwe, bitv} = 2'b11;
            CFB_INVERT_ACC: m_acc = ~m_acc;
            CFB_INVERT_BIT: {bitwe, bitv} = {1'b1, ~bt};
            CFB_ROTATE_LEFT: m_acc = {m_acc[6:0], m_acc[7]};
            CFB_ROTATE_LEFT_C: {m_cy, m_acc} = {m_acc, m_cy};
            CFB_ROTATE_RIGHT: m_acc = {m_acc[0], m_acc[7:1]};
            CFB_ROTATE_RIGHT_C: {m_acc, m_cy} = {m_cy, m_acc};
            CFB_NIBBLE_SWAP: m_acc = {m_acc[3:0], m_acc[7:4]};
            CFB_AND_BYTE, CFB_OR_BYTE, CFB_XOR_BYTE: begin
                bv = (op == CFB_AND_BYTE) ? (f1 & f2) :
                     (op == CFB_OR_BYTE) ? (f1 | f2) : (f1 ^ f2);
                if (dst_sel) begin
                    m_acc = bv;
                end else begin
                    bwe = 1'b1;
                end
            end
            CFB_AND_BIT: m_cy = m_cy & bt;
            CFB_OR_BIT: m_cy = m_cy | bt;
            CFB_SHORT_PAGE_CALL, CFB_LONG_CALL, CFB_PAGE_JUMP,
            CFB_LONG_JUMP: begin
                {jmp, tcare} = 2'b10;
                if (op == CFB_SHORT_PAGE_CALL || op == CFB_PAGE_JUMP) begin
                    nx = m_pc + LEN_PAGE;
                    tgt = {nx[15:11], opc[7:5], i1};
                end else begin
                    nx = m_pc + LEN_LONG;
                    tgt = {i1, i2};
                end
                if (op == CFB_SHORT_PAGE_CALL || op == CFB_LONG_CALL) begin
                    stk[m_sp + 8'h01] = nx[7:0];
                    stk[m_sp + 8'h02] = nx[15:8];
                    m_sp = m_sp + STK_STEP;
                end
            end
            CFB_CALL_EXIT, CFB_INTERRUPT_EXIT: begin
                {jmp, tcare, pr} = {2'b10, op == CFB_INTERRUPT_EXIT};
                tgt = {stk[m_sp], stk[m_sp - 8'h01]};
                m_sp = m_sp - STK_STEP;
            end
            CFB_INDEXED_JUMP: begin
                {jmp, tcare} = 2'b10;
                tgt = {i2, i1} + {8'h00, m_acc};
            end
            CFB_RELATIVE_JUMP: {nx, tk} = {m_pc + LEN_REL, 1'b1};
            CFB_BR_ACC_ZERO: {nx, tk} = {m_pc + LEN_REL, m_acc == 8'h00};
            CFB_BR_ACC_NONZERO: {nx, tk} = {m_pc + LEN_REL, m_acc != 8'h00};
            CFB_BR_CARRY: {nx, tk} = {m_pc + LEN_REL, m_cy};
            CFB_BR_NO_CARRY: {nx, tk} = {m_pc + LEN_REL, ~m_cy};
            CFB_BR_BIT_ONE: {nx, tk} = {m_pc + LEN_BITBR, bt};
            CFB_BR_BIT_ZERO: {nx, tk} = {m_pc + LEN_BITBR, ~bt};
            CFB_BR_TEST_CLEAR: {nx, tk, bitwe} = {m_pc + LEN_BITBR, bt, bt};
            CFB_CMP_BRANCH: begin
                {nx, tk, m_cy} = {m_pc + LEN_CMPBR, f1 != f2, f1 < f2};
            end
            CFB_DEC_BRANCH: begin
                bv = by - 8'h01;
                {bwe, tk} = {1'b1, bv != 8'h00};
            end
            default: ;
        endcase
        if (!jmp) begin
            tgt = tk ? nx + {{8{rl[7]}}, rl} : nx;
        end
        m_pc = tgt;
        q_exp.push_back({8'hff, 8'hff, 16'hffff, 8'hff, 1'b1, {8{bwe}}, 1'b1,
            bitwe, tcare, 1'b1, m_acc, m_cy, m_ac, 3'b000, m_ov, 1'b0,
            ^m_acc, tgt, m_sp, bwe, bv, bitwe, bitv, tk, pr});
    endtask
    task automatic idle();
        @(negedge clk_sys_i);
        op_valid_i = 1'b0;
    endtask
    // Results land one edge after the op; the negedge sees them settled
    always @(posedge clk_sys_i) v_d <= op_valid_i & ~rst_i;
    always @(negedge clk_sys_i) begin
        if (v_d === 1'b1 && q_exp.size() > 0) begin
            ex = q_exp.pop_front();
            chk(obs & ex[105:53], ex[52:0] & ex[105:53]);
        end
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        {m_acc, m_sp, m_pc, m_cy, m_ac, m_ov} = {ACC_RST, STK_RST, PC_RST, 3'b0};
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk({45'h0, acc_o}, {45'h0, ACC_RST});
        chk({21'h0, status_word_o, instruction_counter_o, stack_top_index_o},
            {21'h0, 8'h00, PC_RST, STK_RST});
        do_op(CFB_LONG_JUMP, 8'h02, 8'h01, 8'h1f, 8'h0, 8'h0, 1'b0, 2'h1);
        do_op(CFB_ZERO_ACC, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 1'b0, 2'h2);
        do_op(CFB_ADD, 8'h0, 8'h0, 8'h0, 8'h0, 8'hc3, 1'b0, 2'h1);
        do_op(CFB_ADD, 8'h0, 8'h0, 8'h0, 8'h0, 8'haa, 1'b0, 2'h1);
        do_op(CFB_SHORT_PAGE_CALL, 8'h71, 8'h45, 8'h0, 8'h0, 8'h0, 1'b0,
              2'h1);
        do_op(CFB_CALL_EXIT, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 1'b0, 2'h1);
        do_op(CFB_LONG_CALL, 8'h0, 8'hab, 8'hcd, 8'h0, 8'h0, 1'b0, 2'h1);
        do_op(CFB_INTERRUPT_EXIT, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 1'b0,
              2'h1);
        do_op(CFB_SUBB, 8'h0, 8'h0, 8'h0, 8'h0, 8'h70, 1'b0, 2'h1);
        do_op(CFB_STATUS_WR, 8'h0, 8'h0, 8'h0, 8'h0, 8'hff, 1'b0, 2'h1);
        do_op(CFB_RELATIVE_JUMP, 8'h0, 8'h0, 8'h0, 8'h80, 8'h0, 1'b0,
              2'h1);
        do_op(CFB_DEC_BRANCH, 8'h0, 8'h0, 8'h0, 8'h7f, 8'h01, 1'b0, 2'h3);
        do_op(CFB_CMP_BRANCH, 8'h0, 8'h05, 8'h0, 8'h7f, 8'h05, 1'b0,
              2'h1);
        idle();
        // Each of the 34 table ops once in table order, then a random mix back to back
        for (int i = 0; i < 300; i++) begin
            lfsr = lfsr_step(lfsr);
            dst_sel = lfsr[5];
            do_op(tbl[(i < 34) ? i : (lfsr[15:0] % 34)], lfsr[31:24],
                  lfsr[23:16], lfsr[15:8], lfsr[7:0], lfsr[27:20],
                  lfsr[3], 2'(1 + lfsr[13:10] % 3));
        end
        do_op(CFB_LONG_CALL, 8'h0, 8'h12, 8'h34, 8'h0, 8'h0, 1'b0, 2'h1);
        do_op(CFB_CALL_EXIT, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 1'b0, 2'h1);
        idle();
        repeat (3) @(negedge clk_sys_i);
        conclude();
    end
endmodule
`default_nettype wire
